// ===== design/adcs_cfg.svh
/*
 Holds the offsets, field positions, reset values and timing counts of the scan sequencer.
 Assumes a 10 MHz system clock and inclusion by bare name.
*/
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

`define ADCS_CLK_KHZ 10000
`define ADCS_OSR_MIN_LOG2 6
`define ADCS_OSR_CODES 10
`define ADCS_CONV_MUL 40
`define ADCS_CONV_ADD 170
`define ADCS_F0_HIGH_KHZ 15000
`define ADCS_F0_LOW_KHZ 7500
`define ADCS_EXT_MIN_PERIOD_US 250
`define ADCS_EXT_MIN_CYC ((`ADCS_EXT_MIN_PERIOD_US * `ADCS_CLK_KHZ) / 1000)
`define ADCS_TABLE_DEPTH 128
`define ADCS_FRAME_DELAY_MAX 65535
`define ADCS_PERIOD_RESET 32'h0000_09c4
`define ADCS_ENT_CHAN_LSB 0
`define ADCS_ENT_RANGE_LSB 4
`define ADCS_ENT_KIND_LSB 6
`define ADCS_ENT_W 9

`endif

// ===== design/adcs_pkg.sv
/*
 Types shared by the scan sequencer and its table memory.
 Assumes adcs_cfg.svh is compiled alongside.
*/
package adcs_pkg;
	// Subrange or current step of one entry
	typedef enum logic [1:0] {
		RNG_HI = 2'b00,
		RNG_MID = 2'b01,
		RNG_LO = 2'b10
	} adcs_range_t;

	// Kind of measurement for one entry
	typedef enum logic [2:0] {
		KIND_VOLT = 3'b000,
		KIND_RES = 3'b001,
		KIND_RES_REV = 3'b010,
		KIND_CAL_POS = 3'b011,
		KIND_CAL_NEG = 3'b100,
		KIND_CAL_ZERO = 3'b101
	} adcs_kind_t;

	typedef struct packed {
		adcs_kind_t kind;
		adcs_range_t range;
		logic [3:0] chan;
	} adcs_entry_t;

	// Drive to the analog switch and sources
	typedef struct packed {
		logic [3:0] chan;
		adcs_range_t range;
		logic current_on;
		logic current_rev;
		adcs_range_t excitation_current_source;
		logic cal_on;
		logic [1:0] cal_polarity;
		adcs_range_t calibration_voltage_source;
	} adcs_switch_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_SETTLE = 2'b10,
		ST_GAP = 2'b11
	} adcs_state_t;
endpackage : adcs_pkg

// ===== design/adcs_table_mem.sv
/*
 Control table memory of the scan sequencer, one write port, registered read.
 Assumes writes and reads come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module adcs_table_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire adcs_pkg::adcs_entry_t wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output adcs_pkg::adcs_entry_t rd_data
);
	adcs_pkg::adcs_entry_t mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule : adcs_table_mem
`default_nettype wire

// ===== design/adcs_scan_seq.sv
/*
 Scan sequencer of a precision sigma-delta acquisition module: timing, table walk, switch drive.
 Assumes the converter signals conv_done from logic on clk and that sync_in is an outside pin.
*/
// What this block does
// - Oversample factor programmable as one of ten powers of two, 64 to 32768.
// - Conversion time is (40 times factor plus 170) divided by base frequency.
// - Modulator base frequency is either the higher or the lower setting.
// - Sample period always exceeds conversion time; remainder is settling time.
// - Internal sync derives the sample period by dividing the reference clock.
// - External sync pulses start periods; source keeps them 250 us apart at least.
// - Sample rate shared among channels by cycling a table of up to 128 entries.
// - Each entry chooses one of three voltage subranges independently.
// - Resistance entries drive one of three excitation current levels.
// - Calibration source set to one of three levels for auto-calibration.
// - Each resistance channel uses an input pair, so up to eight such channels.
// - Standard and reversing resistance modes both at full rate; reversing only sets current_rev.
// - Line check runs only while acquisition is disabled.
// - Auto-calibration inserts reference conversions after the last table entry of each frame.
// - Universal line serves either as one-wire master or master-slave sync.
// - Reference reaches the test pins only in the matching program mode.
// - After the last entry, a programmed delay in sample periods precedes wrap.
// - Table walked first to last, then wrapped, switch driven for each entry.
// - Raw converter codes are forwarded with no arithmetic correction.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_cfg.svh"
module adcs_scan_seq #(
	parameter int DEPTH = `ADCS_TABLE_DEPTH,
	parameter int AW = 7,
	parameter int CODE_W = 24,
	parameter int EXT_MIN_CYC = `ADCS_EXT_MIN_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration
	input wire logic [3:0] oversample_factor,
	input wire logic base_freq_low,
	input wire logic [31:0] sample_period,
	input wire logic ext_sync_en,
	input wire logic [AW-1:0] frame_last,
	input wire logic [15:0] frame_delay,
	input wire logic auto_cal_en,
	input wire logic ref_test_mode,
	input wire logic [1:0] ref_test_level,
	input wire logic line_mode_sync,
	input wire logic sync_master,
	// Control
	input wire logic acq_enable,
	input wire logic line_check_req,
	// Table load
	input wire logic table_wr,
	input wire logic [AW-1:0] table_addr,
	input wire adcs_pkg::adcs_entry_t table_data,
	// Converter
	output logic conv_start,
	output logic [3:0] conv_osr_code,
	output logic conv_f0_low,
	input wire logic conv_done,
	input wire logic [CODE_W-1:0] conv_code,
	// Analog switch
	output adcs_pkg::adcs_switch_t switch_drive,
	output logic ref_test_on,
	output logic line_check_on,
	// Universal line
	input wire logic sync_in,
	output logic universal_io_line_o,
	output logic universal_io_line_oe,
	input wire logic owire_out,
	input wire logic owire_oe,
	// Result stream
	output logic result_valid,
	output logic [CODE_W-1:0] result_code,
	output logic [AW-1:0] result_index,
	output logic result_cal,
	// Status
	output logic acq_running,
	output logic config_error,
	output logic [31:0] conversion_time
);
	localparam logic [31:0] CLK_KHZ = 32'(`ADCS_CLK_KHZ);

	// Conversion time in clock cycles, rounded up
	function automatic logic [31:0] conv_cycles(input logic [3:0] code, input logic low);
		logic [47:0] num;
		logic [47:0] f0;
		num = 48'(`ADCS_CONV_MUL) * (48'h1 << (5'(code) + 5'(`ADCS_OSR_MIN_LOG2)))
			+ 48'(`ADCS_CONV_ADD);
		f0 = low ? 48'(`ADCS_F0_LOW_KHZ) : 48'(`ADCS_F0_HIGH_KHZ);
		conv_cycles = 32'((num * 48'(CLK_KHZ) + f0 - 48'h1) / f0);
	endfunction : conv_cycles

	adcs_pkg::adcs_state_t state_r;
	logic [31:0] period_cnt_r;
	logic [31:0] ext_gap_r;
	logic [15:0] gap_cnt_r;
	logic [AW-1:0] idx_r;
	logic cal_slot_r;
	logic cal_pol_r;
	logic [1:0] cal_rng_r;
	logic sync_s1_r;
	logic sync_s2_r;
	logic sync_s3_r;
	logic period_tick;
	logic osr_ok;
	logic period_ok;
	logic start_ok;
	adcs_pkg::adcs_entry_t entry;

	assign osr_ok = oversample_factor < 4'(`ADCS_OSR_CODES);
	assign conversion_time = conv_cycles(oversample_factor, base_freq_low);
	assign period_ok = sample_period > conversion_time;
	assign start_ok = osr_ok && period_ok;
	assign conv_osr_code = oversample_factor;
	assign conv_f0_low = base_freq_low;

	adcs_table_mem #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk(clk),
		.wr_en(table_wr && !acq_running),
		.wr_addr(table_addr),
		.wr_data(table_data),
		.rd_addr(idx_r),
		.rd_data(entry)
	);

	// Sync pin synchroniser
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_s1_r <= 1'b0;
			sync_s2_r <= 1'b0;
			sync_s3_r <= 1'b0;
		end else begin
			sync_s1_r <= sync_in;
			sync_s2_r <= sync_s1_r;
			sync_s3_r <= sync_s2_r;
		end
	end

	// Spacing since last period start, accepted external pulse or divider wrap
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ext_gap_r <= 32'h0000_0000;
		end else if (period_tick) begin
			ext_gap_r <= 32'h0000_0001;
		end else if (ext_gap_r != 32'hffff_ffff) begin
			ext_gap_r <= ext_gap_r + 32'h0000_0001;
		end
	end

	// Internal divider of the reference clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			period_cnt_r <= 32'h0000_0000;
		end else if (!acq_running || period_cnt_r >= sample_period - 32'h0000_0001) begin
			period_cnt_r <= 32'h0000_0000;
		end else begin
			period_cnt_r <= period_cnt_r + 32'h0000_0001;
		end
	end

	// Period start: divider wrap or an external edge far enough from the last
	always_comb begin
		if (ext_sync_en && !(line_mode_sync && sync_master)) begin
			period_tick = acq_running && sync_s2_r && !sync_s3_r
				&& (ext_gap_r >= 32'(EXT_MIN_CYC) || ext_gap_r == 32'h0000_0000);
		end else begin
			period_tick = acq_running && period_cnt_r == 32'h0000_0000;
		end
	end

	// Universal line: sync output in sync mode (driven only when master), one-wire otherwise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			universal_io_line_o <= 1'b0;
			universal_io_line_oe <= 1'b0;
		end else if (line_mode_sync) begin
			universal_io_line_o <= period_tick && sync_master;
			universal_io_line_oe <= sync_master;
		end else begin
			universal_io_line_o <= owire_out;
			universal_io_line_oe <= owire_oe;
		end
	end

	// Acquisition state machine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= adcs_pkg::ST_IDLE;
		end else begin
			unique case (state_r)
				adcs_pkg::ST_IDLE: begin
					if (acq_enable && start_ok) begin
						state_r <= adcs_pkg::ST_SETTLE;
					end
				end
				adcs_pkg::ST_SETTLE: begin
					if (!acq_enable) begin
						state_r <= adcs_pkg::ST_IDLE;
					end else if (period_tick) begin
						state_r <= adcs_pkg::ST_CONV;
					end
				end
				adcs_pkg::ST_CONV: begin
					if (conv_done) begin
						if (!acq_enable) begin
							state_r <= adcs_pkg::ST_IDLE;
						end else if (idx_r == frame_last && !cal_slot_r
							&& (frame_delay != 16'h0000 || auto_cal_en)) begin
							state_r <= adcs_pkg::ST_GAP;
						end else begin
							state_r <= adcs_pkg::ST_SETTLE;
						end
					end
				end
				adcs_pkg::ST_GAP: begin
					if (!acq_enable) begin
						state_r <= adcs_pkg::ST_IDLE;
					end else if (auto_cal_en ? (conv_done && gap_cnt_r == 16'h0000)
						: (period_tick && gap_cnt_r <= 16'h0001)) begin
						state_r <= adcs_pkg::ST_SETTLE;
					end
				end
			endcase
		end
	end

	assign acq_running = state_r != adcs_pkg::ST_IDLE;
	assign config_error = acq_enable && !start_ok && state_r == adcs_pkg::ST_IDLE;
	assign conv_start = period_tick && (state_r == adcs_pkg::ST_SETTLE
		|| (state_r == adcs_pkg::ST_GAP && auto_cal_en));

	// Inter-frame delay counter, one step per sample period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gap_cnt_r <= 16'h0000;
		end else if (state_r == adcs_pkg::ST_CONV && conv_done) begin
			gap_cnt_r <= frame_delay;
		end else if (state_r == adcs_pkg::ST_GAP && period_tick && gap_cnt_r != 16'h0000) begin
			gap_cnt_r <= gap_cnt_r - 16'h0001;
		end
	end

	// Table index walk and calibration slot
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idx_r <= '0;
			cal_slot_r <= 1'b0;
		end else if (state_r == adcs_pkg::ST_IDLE) begin
			idx_r <= '0;
			cal_slot_r <= 1'b0;
		end else if (state_r == adcs_pkg::ST_CONV && conv_done) begin
			if (idx_r == frame_last) begin
				idx_r <= '0;
			end else begin
				idx_r <= idx_r + 1'b1;
			end
		end else if (state_r == adcs_pkg::ST_GAP) begin
			cal_slot_r <= auto_cal_en;
		end else begin
			cal_slot_r <= 1'b0;
		end
	end

	// Calibration reference rotation over subranges and polarities
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cal_pol_r <= 1'b0;
			cal_rng_r <= 2'b00;
		end else if (state_r == adcs_pkg::ST_GAP && conv_done) begin
			cal_pol_r <= !cal_pol_r;
			if (cal_pol_r) begin
				cal_rng_r <= (cal_rng_r == 2'b10) ? 2'b00 : cal_rng_r + 2'b01;
			end
		end
	end

	// Switch drive, refreshed when the next entry is read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			switch_drive <= '0;
		end else if (state_r == adcs_pkg::ST_GAP && auto_cal_en) begin
			switch_drive <= '0;
			switch_drive.cal_on <= 1'b1;
			switch_drive.cal_polarity <= {1'b0, cal_pol_r};
			switch_drive.range <= adcs_pkg::adcs_range_t'(cal_rng_r);
			switch_drive.calibration_voltage_source <= adcs_pkg::adcs_range_t'(cal_rng_r);
		end else if (state_r == adcs_pkg::ST_SETTLE) begin
			switch_drive.range <= entry.range;
			switch_drive.cal_on <= 1'b0;
			switch_drive.cal_polarity <= 2'b00;
			switch_drive.calibration_voltage_source <= adcs_pkg::RNG_HI;
			if (entry.kind == adcs_pkg::KIND_RES || entry.kind == adcs_pkg::KIND_RES_REV) begin
				switch_drive.chan <= {1'b0, entry.chan[2:0]};
				switch_drive.current_on <= 1'b1;
				switch_drive.current_rev <= entry.kind == adcs_pkg::KIND_RES_REV;
				switch_drive.excitation_current_source <= entry.range;
			end else begin
				switch_drive.chan <= entry.chan;
				switch_drive.current_on <= 1'b0;
				switch_drive.current_rev <= 1'b0;
				switch_drive.excitation_current_source <= adcs_pkg::RNG_HI;
			end
		end else if (state_r == adcs_pkg::ST_IDLE) begin
			switch_drive <= '0;
		end
	end

	// Line check and reference test pins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_check_on <= 1'b0;
			ref_test_on <= 1'b0;
		end else begin
			line_check_on <= line_check_req && !acq_enable && !acq_running;
			ref_test_on <= ref_test_mode && !acq_running && ref_test_level != 2'b11;
		end
	end

	// Raw result forwarding
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_valid <= 1'b0;
			result_code <= '0;
			result_index <= '0;
			result_cal <= 1'b0;
		end else begin
			result_valid <= conv_done && (state_r == adcs_pkg::ST_CONV
				|| (state_r == adcs_pkg::ST_GAP && cal_slot_r));
			if (conv_done) begin
				result_code <= conv_code;
				result_index <= idx_r;
				result_cal <= state_r == adcs_pkg::ST_GAP;
			end
		end
	end

	chk_check_idle: assert property (@(posedge clk) disable iff (reset)
		line_check_on |-> !acq_running) else $error("line check during acquisition");
	chk_refuse_bad: assert property (@(posedge clk) disable iff (reset)
		(state_r == adcs_pkg::ST_IDLE && !start_ok) |=> state_r == adcs_pkg::ST_IDLE)
		else $error("started with bad period");
	chk_raw_code: assert property (@(posedge clk) disable iff (reset)
		$rose(result_valid) |-> result_code == $past(conv_code))
		else $error("result code altered");
	chk_idx_wrap: assert property (@(posedge clk) disable iff (reset)
		(state_r == adcs_pkg::ST_CONV && conv_done && idx_r == frame_last) |=> idx_r == '0)
		else $error("table did not wrap");
	chk_idx_step: assert property (@(posedge clk) disable iff (reset)
		(state_r == adcs_pkg::ST_CONV && conv_done && idx_r != frame_last && acq_enable)
		|=> idx_r == $past(idx_r) + 1'b1 && state_r != adcs_pkg::ST_CONV)
		else $error("index not advanced after result");
	chk_ext_spacing: assert property (@(posedge clk) disable iff (reset)
		(ext_sync_en && !(line_mode_sync && sync_master) && period_tick) |=> !period_tick[*8])
		else $error("external periods too close");
	chk_res_pair: assert property (@(posedge clk) disable iff (reset)
		switch_drive.current_on |-> switch_drive.chan[3] == 1'b0)
		else $error("resistance channel outside pair range");
	chk_ref_pins: assert property (@(posedge clk) disable iff (reset)
		ref_test_on |-> $past(ref_test_mode)) else $error("reference on pins unselected");
	chk_osr_range: assert property (@(posedge clk) disable iff (reset)
		acq_running && $past(state_r) == adcs_pkg::ST_IDLE |-> $past(osr_ok))
		else $error("started with bad factor");
	chk_int_period: assert property (@(posedge clk) disable iff (reset)
		(!ext_sync_en && period_tick && $past(acq_running)) |-> ext_gap_r == sample_period)
		else $error("internal period wrong");
endmodule : adcs_scan_seq
`default_nettype wire

// ===== verification/adcs_conv_model.sv
/*
 Behavioural converter: answers each start that arrives while idle with a fresh code after a chosen delay.
 Assumes starts come from logic on clk and the code line means nothing outside done.
*/
`timescale 1ns/1ps
`default_nettype none
module adcs_conv_model (
	// Clock
	input wire logic clk,
	// From the sequencer
	input wire logic conv_start,
	input wire logic [7:0] delay_cyc,
	// Answer
	output logic conv_done,
	output logic [23:0] conv_code,
	output logic [23:0] sent_code
);
	int cnt = 0;
	logic busy = 1'b0;
	logic [23:0] seq = 24'h5a1c33;
	initial begin
		conv_done = 1'b0;
		conv_code = 24'h000000;
		sent_code = 24'h000000;
	end
	always @(posedge clk) begin
		conv_done <= 1'b0;
		conv_code <= ~conv_code;
		if (conv_start && !busy) begin
			busy <= 1'b1;
			cnt <= delay_cyc;
		end else if (busy && cnt > 0) begin
			cnt <= cnt - 1;
		end else if (busy) begin
			// Raw code, one per start
			busy <= 1'b0;
			conv_done <= 1'b1;
			conv_code <= seq;
			sent_code <= seq;
			seq <= {seq[22:0], seq[23] ^ seq[22] ^ seq[21] ^ seq[16]};
		end
	end
endmodule : adcs_conv_model
`default_nettype wire

// ===== verification/adcs_scan_seq_tb.sv
/*
 Self-checking bench of the scan sequencer with a converter model.
 Assumes the design sources and package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module adcs_scan_seq_tb;
	logic clk, reset, base_freq_low, ext_sync_en, auto_cal_en, ref_test_mode, line_mode_sync;
	logic sync_master, acq_enable, line_check_req, table_wr, sync_in, owire_out, owire_oe;
	logic [3:0] oversample_factor;
	logic [31:0] sample_period, conversion_time;
	logic [6:0] frame_last, table_addr, result_index;
	logic [15:0] frame_delay;
	logic [1:0] ref_test_level;
	adcs_pkg::adcs_entry_t table_data, e;
	adcs_pkg::adcs_entry_t tbl [0:127];
	adcs_pkg::adcs_switch_t switch_drive;
	logic conv_start, conv_f0_low, conv_done, ref_test_on, line_check_on, uo, uoe, result_valid;
	logic result_cal, acq_running, config_error, walk_chk, start_d;
	logic [3:0] conv_osr_code, mask;
	logic [23:0] conv_code, result_code, sent_code;
	logic [7:0] delay_cyc;
	int fails = 0, check_count = 0, cyc = 0, ks, kr, ncal, last_t, nent, fdel, per;

	adcs_scan_seq #(.EXT_MIN_CYC(20)) dut_u (.clk(clk), .reset(reset),
		.oversample_factor(oversample_factor), .base_freq_low(base_freq_low),
		.sample_period(sample_period), .ext_sync_en(ext_sync_en), .frame_last(frame_last),
		.frame_delay(frame_delay), .auto_cal_en(auto_cal_en), .ref_test_mode(ref_test_mode),
		.ref_test_level(ref_test_level), .line_mode_sync(line_mode_sync),
		.sync_master(sync_master), .acq_enable(acq_enable), .line_check_req(line_check_req),
		.table_wr(table_wr), .table_addr(table_addr), .table_data(table_data),
		.conv_start(conv_start), .conv_osr_code(conv_osr_code), .conv_f0_low(conv_f0_low),
		.conv_done(conv_done), .conv_code(conv_code), .switch_drive(switch_drive),
		.ref_test_on(ref_test_on), .line_check_on(line_check_on), .sync_in(sync_in),
		.universal_io_line_o(uo), .universal_io_line_oe(uoe), .owire_out(owire_out),
		.owire_oe(owire_oe), .result_valid(result_valid), .result_code(result_code),
		.result_index(result_index), .result_cal(result_cal), .acq_running(acq_running),
		.config_error(config_error), .conversion_time(conversion_time));
	adcs_conv_model model_u (.clk(clk), .conv_start(conv_start), .delay_cyc(delay_cyc),
		.conv_done(conv_done), .conv_code(conv_code), .sent_code(sent_code));

	always #50 clk = ~clk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (exp !== got) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// Conversion time in clock cycles, rounded up
	function automatic logic [31:0] exp_ct(input int n, input logic low);
		longint num;
		longint den;
		num = (40 * (longint'(64) << n) + 170) * 10000;
		den = low ? 7500 : 15000;
		return 32'((num + den - 1) / den);
	endfunction : exp_ct

	// Watches starts and results
	always @(posedge clk) begin
		cyc++;
		if (sync_master)
			chk("sync_out", 32'(start_d), 32'(uo));
		start_d = conv_start;
		if (conv_start) begin
			if (walk_chk && ks > 0) begin
				e = tbl[ks % nent];
				mask = (e.kind == adcs_pkg::KIND_VOLT) ? 4'hf : 4'h7;
				chk("chan", 32'(e.chan & mask), 32'(switch_drive.chan));
				chk("current_on", 32'(e.kind != adcs_pkg::KIND_VOLT), 32'(switch_drive.current_on));
				chk("current_rev", 32'(e.kind == adcs_pkg::KIND_RES_REV), 32'(switch_drive.current_rev));
				if (e.kind == adcs_pkg::KIND_VOLT)
					chk("range", 32'(e.range), 32'(switch_drive.range));
				else
					chk("current", 32'(e.range), 32'(switch_drive.excitation_current_source));
				chk("period", ((ks - 1) % nent == nent - 1) ? (fdel + 1) * per : per, cyc - last_t);
			end
			ks++;
			last_t = cyc;
		end
		if (result_valid) begin
			chk("code", 32'(sent_code), 32'(result_code));
			if (result_cal) begin
				chk("cal_lvl", (ncal / 2) % 3, 32'(switch_drive.calibration_voltage_source));
				chk("cal_pol", ncal % 2, 32'(switch_drive.cal_polarity));
				chk("cal_on", 1, 32'(switch_drive.cal_on));
				ncal++;
			end else begin
				chk("index", kr % nent, 32'(result_index));
				kr++;
			end
		end
		if (cyc > 95000) begin
			fails++;
			summarize();
		end
	end

	task automatic run(input int n, input int fd, input logic cal, input logic ext, input int nres);
		int t;
		nent = n;
		fdel = fd;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			tbl[i] = {3'($urandom % 3), 2'($urandom % 3), 4'($urandom)};
			table_wr = 1'b1;
			table_addr = 7'(i);
			table_data = tbl[i];
		end
		@(negedge clk);
		table_wr = 1'b0;
		frame_last = 7'(n - 1);
		frame_delay = 16'(fd);
		auto_cal_en = cal;
		ext_sync_en = ext;
		oversample_factor = 4'h0;
		base_freq_low = 1'b0;
		per = 1821 + int'($urandom % 40);
		sample_period = 32'(per);
		ks = 0;
		kr = 0;
		ncal = 0;
		walk_chk = !cal && !ext;
		acq_enable = 1'b1;
		@(negedge clk);
		chk("running", 1, 32'(acq_running));
		table_wr = 1'b1;
		table_addr = 7'h00;
		table_data = ~tbl[0];
		line_check_req = 1'b1;
		@(negedge clk);
		table_wr = 1'b0;
		@(negedge clk);
		chk("check_on_run", 0, 32'(line_check_on));
		line_check_req = 1'b0;
		t = 0;
		while (kr + ncal < nres && t < 40000) begin
			@(negedge clk);
			t++;
		end
		chk("results", 1, 32'(kr + ncal >= nres));
	endtask : run

	task automatic stop();
		int t;
		acq_enable = 1'b0;
		t = 0;
		while (acq_running !== 1'b0 && t < 3000) begin
			@(negedge clk);
			t++;
		end
		chk("stopped", 0, 32'(acq_running));
		walk_chk = 1'b0;
	endtask : stop

	task automatic pulse(input int gap);
		repeat (gap - 2) @(negedge clk);
		sync_in = 1'b1;
		repeat (2) @(negedge clk);
		sync_in = 1'b0;
	endtask : pulse

	initial begin
		clk = 1'b0; reset = 1'b1; oversample_factor = 4'h0; base_freq_low = 1'b0;
		sample_period = 32'h0000_0000; ext_sync_en = 1'b0; frame_last = 7'h00;
		frame_delay = 16'h0000; auto_cal_en = 1'b0; ref_test_mode = 1'b0; ref_test_level = 2'h3;
		line_mode_sync = 1'b0; sync_master = 1'b0; acq_enable = 1'b0; line_check_req = 1'b0;
		table_wr = 1'b0; table_addr = 7'h00; table_data = '0; sync_in = 1'b0;
		owire_out = 1'b0; owire_oe = 1'b0; delay_cyc = 8'h04; walk_chk = 1'b0; nent = 1;
		void'($urandom(22853));
		repeat (20) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		chk("switch_rst", 0, 32'(switch_drive));
		chk("valid_rst", 0, 32'(result_valid));
		// Every factor code and both base frequencies, refused periods
		for (int n = 0; n < 16; n++) begin
			for (int f = 0; f < 2; f++) begin
				@(negedge clk);
				oversample_factor = 4'(n);
				base_freq_low = 1'(f);
				sample_period = (n < 10) ? exp_ct(n, 1'(f)) : 32'hffff_ffff;
				acq_enable = 1'b1;
				#1;
				chk("osr_code", 32'(n), 32'(conv_osr_code));
				chk("f0_low", 32'(f), 32'(conv_f0_low));
				if (n < 10)
					chk("conv_time", exp_ct(n, 1'(f)), conversion_time);
				chk("cfg_err", 1, 32'(config_error));
				@(negedge clk);
				chk("no_start", 0, 32'(acq_running));
				acq_enable = 1'b0;
			end
		end
		// Idle-side functions
		line_check_req = 1'b1;
		owire_out = 1'($urandom);
		owire_oe = 1'b1;
		ref_test_mode = 1'b1;
		for (int l = 0; l < 4; l++) begin
			ref_test_level = 2'(l);
			repeat (3) @(negedge clk);
			chk("ref_test", 32'(l != 3), 32'(ref_test_on));
		end
		chk("check_on_idle", 1, 32'(line_check_on));
		chk("owire_o", 32'(owire_out), 32'(uo));
		chk("owire_oe", 1, 32'(uoe));
		ref_test_mode = 1'b0;
		line_check_req = 1'b0;
		line_mode_sync = 1'b1;
		repeat (3) @(negedge clk);
		chk("ref_off", 0, 32'(ref_test_on));
		chk("slave_oe", 0, 32'(uoe));
		// Table walks, prompt and slow converter, frame gap, calibration
		sync_master = 1'b1;
		run(4, 0, 1'b0, 1'b0, 10);
		stop();
		sync_master = 1'b0;
		delay_cyc = 8'd200;
		run(3, 2, 1'b0, 1'b0, 7);
		stop();
		delay_cyc = 8'h04;
		run(2, 2, 1'b1, 1'b0, 8);
		stop();
		chk("cal_count", 4, ncal);
		// External sync: a pulse too close to the last is ignored
		run(2, 0, 1'b0, 1'b1, 0);
		pulse(60);
		pulse(60);
		pulse(60);
		pulse(10);
		pulse(60);
		repeat (20) @(negedge clk);
		chk("ext_starts", 4, ks);
		stop();
		summarize();
	end
endmodule : adcs_scan_seq_tb
`default_nettype wire
